// ### logic/pla_pkg.sv
// Purpose: Shared constants for the programmable logic fabric.
// Assumes: Wishbone byte addresses, 32-bit data, one word per register.
// Notes:   Element index 0..7 is block 0, 8..15 is block 1.
package pla_pkg;

  localparam int unsigned NUM_ELEMENTS    = 16;
  localparam int unsigned ELEMS_PER_BLOCK = 8;
  localparam int unsigned WB_ADR_W        = 8;
  localparam int unsigned ELEM_CFG_W      = 11;
  localparam int unsigned NUM_CLK_SRC     = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_ELEM_BASE    = 8'h00;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h40;
  localparam logic [7:0] OFS_INT_ROUTE    = 8'h44;
  localparam logic [7:0] OFS_TRIG_ROUTE   = 8'h48;
  localparam logic [7:0] OFS_SOFT_IN      = 8'h4C;
  localparam logic [7:0] OFS_OUT_WORD     = 8'h50;

  // Writable bits of each register, then the common reset value; the rest read as zero
  localparam logic [31:0] ELEM_MASK  = 32'h0000_07FF;
  localparam logic [31:0] CLOCK_MASK = 32'h0000_0077;
  localparam logic [31:0] INT_MASK   = 32'h0000_1F1F;
  localparam logic [31:0] TRIG_MASK  = 32'h0000_001F;
  localparam logic [31:0] SOFT_MASK  = 32'h0000_FFFF;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;

  // Element configuration fields
  localparam int unsigned ELEM_FB0_LSB    = 9;
  localparam int unsigned ELEM_FB1_LSB    = 7;
  localparam int unsigned ELEM_B_SEL_BIT  = 6;
  localparam int unsigned ELEM_A_SEL_BIT  = 5;
  localparam int unsigned ELEM_LUT_LSB    = 1;
  localparam int unsigned ELEM_BYPASS_BIT = 0;

  // Clock select, interrupt route and trigger route fields
  localparam int unsigned CLK_BLK0_LSB  = 0;
  localparam int unsigned CLK_BLK1_LSB  = 4;
  localparam int unsigned LOGIC_INTERRUPT_ZERO_SRC_LSB  = 0;
  localparam int unsigned LOGIC_INTERRUPT_ZERO_EN_BIT   = 4;
  localparam int unsigned LOGIC_INTERRUPT_ONE_SRC_LSB  = 8;
  localparam int unsigned LOGIC_INTERRUPT_ONE_EN_BIT   = 12;
  localparam int unsigned TRIG_SRC_LSB  = 0;
  localparam int unsigned TRIG_EN_BIT   = 4;

  typedef enum logic [2:0] {
    CLK_PIN_A   = 3'h0,
    CLK_PIN_B   = 3'h1,
    CLK_PIN_C   = 3'h2,
    CLK_CORE    = 3'h3,
    CLK_CRYSTAL = 3'h4,
    CLK_TIMER1  = 3'h5,
    CLK_TIMER4  = 3'h6
  } clk_src_e;

endpackage

// ### logic/clock_source_select.sv
// Purpose: Turns the selected block clock source into a one-cycle capture enable.
// Assumes: All sources are synchronous to clk_i and slower than half its rate.
// Notes:   Core clock selection enables capture on every cycle.
`timescale 1ns/1ps
module clock_source_select
  import pla_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic [2:0]             sel_i,
  input  wire logic [NUM_CLK_SRC-1:0] src_i,
  output logic                        tick_o
);

  logic [NUM_CLK_SRC-1:0] prev;
  wire  [NUM_CLK_SRC-1:0] rise = src_i & ~prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else if (ce_i) begin
      prev <= src_i;
    end
  end

  // Reserved codes stop the block's flip-flops
  always_comb begin
    case (clk_src_e'(sel_i))
      CLK_PIN_A:   tick_o = rise[0];
      CLK_PIN_B:   tick_o = rise[1];
      CLK_PIN_C:   tick_o = rise[2];
      CLK_CORE:    tick_o = 1'b1;
      CLK_CRYSTAL: tick_o = rise[3];
      CLK_TIMER1:  tick_o = rise[4];
      CLK_TIMER4:  tick_o = rise[5];
      default:     tick_o = 1'b0;
    endcase
  end

endmodule

// ### logic/logic_element.sv
// Purpose: One fabric element: input muxes, two-input lookup, bypassable flop.
// Assumes: Config word comes straight from the element's register.
// Notes:   A bypassed element in a feedback ring forms a combinational loop.
`timescale 1ns/1ps
module logic_element
  import pla_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  tick_i,
  input  wire logic [ELEM_CFG_W-1:0] config_i,
  input  wire logic [3:0]            fb0_i,
  input  wire logic [3:0]            fb1_i,
  input  wire logic                  pin_i,
  input  wire logic                  soft_i,
  output logic                       out_o
);

  logic q;
  wire [1:0] sel0   = config_i[ELEM_FB0_LSB +: 2];
  wire [1:0] sel1   = config_i[ELEM_FB1_LSB +: 2];
  wire [3:0] lut    = config_i[ELEM_LUT_LSB +: 4];
  wire       mux0   = fb0_i[sel0];
  wire       mux1   = fb1_i[sel1];
  wire       in_b   = config_i[ELEM_B_SEL_BIT] ? mux1 : soft_i;
  wire       in_a   = config_i[ELEM_A_SEL_BIT] ? pin_i : mux0;
  // Code bit {A,B} is the function value for that input pair
  wire       lut_out = lut[{in_a, in_b}];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= 1'b0;
    end else if (ce_i && tick_i) begin
      q <= lut_out;
    end
  end

  assign out_o = config_i[ELEM_BYPASS_BIT] ? lut_out : q;

endmodule

// ### logic/programmable_logic_array.sv
// Purpose: Sixteen-element programmable logic fabric with a Wishbone register port.
// Assumes: Classic Wishbone slave, byte addresses, all inputs synchronous to clk_i.
// Notes:   Block flop clocks are capture enables derived from the selected source.
`timescale 1ns/1ps

// Functional notes
// - Two blocks of eight elements; elements 0-7 and 8-15.
// - Each element has a two-input lookup table followed by a flip-flop.
// - Sixteen input pins feed elements; element outputs drive output pins.
// - Comparator output replaces one element input pin.
// - Outputs route to interrupts, converter trigger, readable register, pins.
// - Element 15 feeds element 0 mux0 input 0; element 7 feeds element 8.
// - Twenty-one registers: sixteen element configs plus five shared registers.
// - Config bits 10-9 pick first feedback source per the element table.
// - Config bits 8-7 pick odd element of own block as second feedback.
// - Bit 6 set takes second feedback; clear takes the soft input bit.
// - Bit 5 set takes the input pin; clear takes first feedback.
// - Bits 4-1 pick function: 0000 zero, 0001 NOR, 0010 B and not A.
// - Clock select register picks flop clock per block separately.
// - Interrupt route register enables two interrupts and picks their elements.
// - Trigger route register picks element driving converter start.
// - Output word always shows current element outputs.
// - Bit 0 set bypasses the flop; clear uses the registered value.
// - Three-bit clock code: pins, core, crystal, timer overflows, rest reserved.
// - Interrupt enables bits 12 and 4, sources bits 11-8 and 3-0.
module programmable_logic_array
  import pla_pkg::*;
#(
  parameter int unsigned CMP_ELEMENT = 7
)(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [WB_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [NUM_ELEMENTS-1:0] pin_in_i,
  input  wire logic                    comparator_i,
  input  wire logic [2:0]              flop_clk_pin_i,
  input  wire logic                    crystal_clock_source_i,
  input  wire logic                    timer1_overflow_i,
  input  wire logic                    timer4_overflow_i,
  output logic      [NUM_ELEMENTS-1:0] pin_out_o,
  output logic                         logic_interrupt_zero_o,
  output logic                         logic_interrupt_one_o,
  output logic                         converter_start_trigger_o
);

  if (CMP_ELEMENT >= NUM_ELEMENTS) begin : g_bad_cmp
    $error("CMP_ELEMENT must name one of the sixteen elements");
  end

  // Registers
  logic [31:0] element_config [NUM_ELEMENTS];
  logic [31:0] flop_clock_select;
  logic [31:0] logic_interrupt_route;
  logic [31:0] conversion_trigger_route;
  logic [31:0] soft_input_word;

  wire  [NUM_ELEMENTS-1:0] elem_out;
  wire  [NUM_ELEMENTS-1:0] elem_pin;
  wire  [1:0]              blk_tick;

  // Bus decode
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_go     = bus_req & wb_we_i & ce_i;
  wire [5:0]  word_addr = wb_adr_i[WB_ADR_W-1:2];
  wire [3:0]  elem_idx  = wb_adr_i[5:2];
  wire        elem_hit  = (wb_adr_i[7:6] == OFS_ELEM_BASE[7:6]);
  wire        clk_hit   = (word_addr == OFS_CLOCK_SELECT[7:2]);
  wire        int_hit   = (word_addr == OFS_INT_ROUTE[7:2]);
  wire        trig_hit  = (word_addr == OFS_TRIG_ROUTE[7:2]);
  wire        soft_hit  = (word_addr == OFS_SOFT_IN[7:2]);
  wire        out_hit   = (word_addr == OFS_OUT_WORD[7:2]);

  // Readback; unmapped words read zero and still acknowledge
  wire [31:0] out_word  = {16'h0000, elem_out};
  wire [31:0] rd_word   = elem_hit ? element_config[elem_idx] :
                          clk_hit  ? flop_clock_select :
                          int_hit  ? logic_interrupt_route :
                          trig_hit ? conversion_trigger_route :
                          soft_hit ? soft_input_word :
                          out_hit  ? out_word : 32'h0000_0000;

  // Byte-lane merge so partial writes keep the other lanes
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] merged    = (rd_word & ~lane_mask) | (wb_dat_i & lane_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NUM_ELEMENTS; k++) begin
        element_config[k] <= REG_RESET;
      end
    end else if (wr_go && elem_hit) begin
      element_config[elem_idx] <= merged & ELEM_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flop_clock_select <= REG_RESET;
    end else if (wr_go && clk_hit) begin
      flop_clock_select <= merged & CLOCK_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logic_interrupt_route <= REG_RESET;
    end else if (wr_go && int_hit) begin
      logic_interrupt_route <= merged & INT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_trigger_route <= REG_RESET;
    end else if (wr_go && trig_hit) begin
      conversion_trigger_route <= merged & TRIG_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_input_word <= REG_RESET;
    end else if (wr_go && soft_hit) begin
      soft_input_word <= merged & SOFT_MASK;
    end
  end

  // Block clock sources; order matches the source bus of the selector
  wire [NUM_CLK_SRC-1:0] clk_src = {timer4_overflow_i, timer1_overflow_i,
                                    crystal_clock_source_i, flop_clk_pin_i};

  clock_source_select u_clk_blk0 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sel_i  (flop_clock_select[CLK_BLK0_LSB +: 3]),
    .src_i  (clk_src),
    .tick_o (blk_tick[0])
  );

  clock_source_select u_clk_blk1 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sel_i  (flop_clock_select[CLK_BLK1_LSB +: 3]),
    .src_i  (clk_src),
    .tick_o (blk_tick[1])
  );

  // The comparator takes over one pin so its level can enter the fabric
  for (genvar p = 0; p < NUM_ELEMENTS; p++) begin : g_pin
    assign elem_pin[p] = (p == CMP_ELEMENT) ? comparator_i : pin_in_i[p];
  end

  for (genvar g = 0; g < NUM_ELEMENTS; g++) begin : g_elem
    localparam int unsigned BASE = (g / ELEMS_PER_BLOCK) * ELEMS_PER_BLOCK;
    localparam int unsigned LOC  = g % ELEMS_PER_BLOCK;
    // First element of a block takes the other block's last element
    localparam int unsigned F0   = (LOC == 0) ? (g + 15) % NUM_ELEMENTS : BASE;

    wire [3:0] fb0 = {elem_out[BASE+6], elem_out[BASE+4],
                      elem_out[BASE+2], elem_out[F0]};
    wire [3:0] fb1 = {elem_out[BASE+7], elem_out[BASE+5],
                      elem_out[BASE+3], elem_out[BASE+1]};

    logic_element u_elem (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .tick_i   (blk_tick[g / ELEMS_PER_BLOCK]),
      .config_i (element_config[g][ELEM_CFG_W-1:0]),
      .fb0_i    (fb0),
      .fb1_i    (fb1),
      .pin_i    (elem_pin[g]),
      .soft_i   (soft_input_word[g]),
      .out_o    (elem_out[g])
    );
  end

  // Routing of element outputs
  wire [3:0] logic_interrupt_zero_src = logic_interrupt_route[LOGIC_INTERRUPT_ZERO_SRC_LSB +: 4];
  wire [3:0] logic_interrupt_one_src = logic_interrupt_route[LOGIC_INTERRUPT_ONE_SRC_LSB +: 4];
  wire [3:0] trig_src = conversion_trigger_route[TRIG_SRC_LSB +: 4];
  wire       logic_interrupt_zero_nxt = logic_interrupt_route[LOGIC_INTERRUPT_ZERO_EN_BIT] & elem_out[logic_interrupt_zero_src];
  wire       logic_interrupt_one_nxt = logic_interrupt_route[LOGIC_INTERRUPT_ONE_EN_BIT] & elem_out[logic_interrupt_one_src];
  wire       trig_nxt = conversion_trigger_route[TRIG_EN_BIT] & elem_out[trig_src];

  // Registered outputs add one cycle but keep glitches off the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o                 <= '0;
      logic_interrupt_zero_o    <= 1'b0;
      logic_interrupt_one_o     <= 1'b0;
      converter_start_trigger_o <= 1'b0;
    end else if (ce_i) begin
      pin_out_o                 <= elem_out;
      logic_interrupt_zero_o    <= logic_interrupt_zero_nxt;
      logic_interrupt_one_o     <= logic_interrupt_one_nxt;
      converter_start_trigger_o <= trig_nxt;
    end
  end

endmodule

// ### verif/pla_props.sv
// Purpose: Port-level assertions for the programmable logic fabric.
// Assumes: Classic Wishbone single cycles; one clock domain.
// Notes:   Route enables are mirrored from bus writes seen at ack.
`timescale 1ns/1ps
module pla_props
  import pla_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [WB_ADR_W-1:0]     wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic [NUM_ELEMENTS-1:0] pin_out_o,
  input wire logic                    logic_interrupt_zero_o,
  input wire logic                    logic_interrupt_one_o,
  input wire logic                    converter_start_trigger_o
);
  logic en0, en1, ten;
  wire  rd_ack  = wb_ack_o && !wb_we_i;
  wire  int_wr  = wb_ack_o && wb_we_i && wb_adr_i[7:2] == OFS_INT_ROUTE[7:2];
  wire  trig_wr = wb_ack_o && wb_we_i && wb_adr_i[7:2] == OFS_TRIG_ROUTE[7:2];
  // Mirror lags the register by one edge, as the gated outputs do
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en0 <= 1'b0;
      en1 <= 1'b0;
      ten <= 1'b0;
    end else begin
      if (int_wr && wb_sel_i[0]) en0 <= wb_dat_i[LOGIC_INTERRUPT_ZERO_EN_BIT];
      if (int_wr && wb_sel_i[1]) en1 <= wb_dat_i[LOGIC_INTERRUPT_ONE_EN_BIT];
      if (trig_wr && wb_sel_i[0]) ten <= wb_dat_i[TRIG_EN_BIT];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  cfg_reserved_a: assert property (rd_ack && wb_adr_i < OFS_CLOCK_SELECT |-> wb_dat_o[31:11] == 21'h0)
    else $error("reserved config bits set");
  irq_zero_gate_a: assert property (logic_interrupt_zero_o |-> en0)
    else $error("interrupt zero while disabled");
  irq_one_gate_a: assert property (logic_interrupt_one_o |-> en1)
    else $error("interrupt one while disabled");
  trig_gate_a: assert property (converter_start_trigger_o |-> ten)
    else $error("trigger while disabled");
  outword_match_a: assert property (rd_ack && wb_adr_i == OFS_OUT_WORD |-> wb_dat_o[15:0] == pin_out_o)
    else $error("output word differs from pins");
  reset_clear_a: assert property ($fell(rst_i) |-> pin_out_o == '0 && !logic_interrupt_one_o)
    else $error("outputs not clear after reset");
endmodule
bind programmable_logic_array pla_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out_o(pin_out_o),
  .logic_interrupt_zero_o(logic_interrupt_zero_o), .logic_interrupt_one_o(logic_interrupt_one_o),
  .converter_start_trigger_o(converter_start_trigger_o)
);

// ### verif/port_pin_model.sv
// Purpose: Port pins and clock sources on the fabric's far side.
// Assumes: Source requests are one cycle wide.
// Notes:   Pins not given to the fabric carry other traffic.
`timescale 1ns/1ps
module port_pin_model (
  input  wire logic        clk_i,
  input  wire logic        fabric_mode_i,
  input  wire logic [15:0] level_i,
  input  wire logic        cmp_level_i,
  input  wire logic [5:0]  pulse_req_i,
  output logic      [15:0] pin_in_o,
  output logic             comparator_o,
  output logic      [2:0]  clk_pin_o,
  output logic             crystal_o,
  output logic             timer1_o,
  output logic             timer4_o
);
  logic [5:0] d1   = 6'h0;
  logic [5:0] d2   = 6'h0;
  logic       flip = 1'b0;
  // Three cycles high keeps each source below half the core rate
  wire  [5:0] src  = pulse_req_i | d1 | d2;
  always @(posedge clk_i) begin
    d1 <= pulse_req_i;
    d2 <= d1;
    flip <= ~flip;
  end
  assign pin_in_o     = fabric_mode_i ? level_i : {16{flip}};
  assign comparator_o = cmp_level_i;
  assign clk_pin_o    = src[2:0];
  assign crystal_o    = src[3];
  assign timer1_o     = src[4];
  assign timer4_o     = src[5];
endmodule

// ### verif/programmable_logic_array_tb_top.sv
// Purpose: Self-checking bench for the programmable logic fabric.
// Assumes: ce_i held high; clock sources come from the pin model.
// Notes:   Bypassed elements are never chained into a ring.
`timescale 1ns/1ps
module programmable_logic_array_tb_top
  import pla_pkg::*;
;
  logic        clk_i, rst_i = 1, cyc = 0, we = 0, fab = 0, cmp = 0, q = 0, nv;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wd = 0, dat_o, rd;
  logic        ack, logic_interrupt_zero, logic_interrupt_one, trig, xtal, t1, t4, cmp_pin;
  logic [15:0] lvl = 0, pin_in, pin_out;
  logic [5:0]  req = 0;
  logic [2:0]  cpin;
  int          miscompares = 0, check_count = 0;
  // Function code beside its truth table, indexed by {A,B}
  logic [7:0]  lut [16] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77,
                            8'h88, 8'h99, 8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'hEE, 8'hFF};
  int          fb [12] = '{15, 2, 4, 6, 1, 3, 5, 7, 7, 10, 12, 14};
  logic [7:0]  ra [5] = '{8'h44, 8'h44, 8'h48, 8'h44, 8'h48};
  logic [31:0] rv [5] = '{32'h13, 32'h1300, 32'h13, 32'h0303, 32'h03};
  logic [2:0]  re [5] = '{3'h2, 3'h4, 3'h5, 3'h1, 3'h0};
  programmable_logic_array DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin_in_i(pin_in), .comparator_i(cmp_pin), .flop_clk_pin_i(cpin),
    .crystal_clock_source_i(xtal), .timer1_overflow_i(t1), .timer4_overflow_i(t4),
    .pin_out_o(pin_out), .logic_interrupt_zero_o(logic_interrupt_zero), .logic_interrupt_one_o(logic_interrupt_one),
    .converter_start_trigger_o(trig));
  port_pin_model partner (
    .clk_i(clk_i), .fabric_mode_i(fab), .level_i(lvl), .cmp_level_i(cmp), .pulse_req_i(req),
    .pin_in_o(pin_in), .comparator_o(cmp_pin), .clk_pin_o(cpin), .crystal_o(xtal),
    .timer1_o(t1), .timer4_o(t4));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // No fixed latency assumed; the bound only catches a dead bus
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    if (n >= 20) miscompares++;
    if (n >= 20) stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdw(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    fab <= 1'b1;
    for (int r = 0; r < 16; r++) begin
      wr(8'h00, 32'h21 | 32'(lut[r][7:4]) << 1);
      for (int k = 0; k < 4; k++) begin
        lvl[0] <= k[1];
        wr(OFS_SOFT_IN, 32'(k[0]));
        rdw(OFS_OUT_WORD);
        check(rd[0], lut[r][k]);
        check(pin_out[0], lut[r][k]);
      end
    end
    for (int e = 1; e < 16; e++) wr(8'(4 * e), 32'h39);
    for (int i = 0; i < 12; i++) begin
      wr(i < 8 ? 8'h00 : 8'h20, i < 4 ? 32'h19 | 32'(i) << 9 :
         i < 8 ? 32'h55 | 32'(i - 4) << 7 : 32'h19 | 32'(i - 8) << 9);
      lvl <= fb[i] == 7 ? 16'h0000 : 16'(1 << fb[i]);
      cmp <= (fb[i] == 7);
      rdw(OFS_OUT_WORD);
      check(rd[i < 8 ? 0 : 8], 1'b1);
    end
    wr(8'h00, 32'h38);
    wr(8'h20, 32'h38);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CLOCK_SELECT, 32'(c));
      nv = ~q;
      lvl[0] <= nv;
      rdw(OFS_OUT_WORD);
      check(rd[0], c == 3 ? nv : q);
      req <= c == 7 ? 6'h3F : 6'(1 << (c < 3 ? c : c - 1));
      @(posedge clk_i);
      req <= 6'h0;
      repeat (4) @(posedge clk_i);
      rdw(OFS_OUT_WORD);
      check(rd[0], c == 7 ? q : nv);
      q = c == 7 ? q : nv;
    end
    wr(OFS_CLOCK_SELECT, 32'h30);
    lvl[8] <= 1'b1;
    lvl[0] <= ~q;
    rdw(OFS_OUT_WORD);
    check({rd[8], rd[0]}, {1'b1, q});
    wr(8'h0C, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rv[i]);
      rdw(OFS_OUT_WORD);
      check({logic_interrupt_one, logic_interrupt_zero, trig}, re[i]);
    end
    for (int a = 0; a < 'h50; a += 4) begin
      wr(8'(a), 32'hFFFF_FFBE);
      rdw(8'(a));
      check(rd, 32'hFFFF_FFBE & (a < 'h40 ? ELEM_MASK : a == 'h40 ? CLOCK_MASK :
            a == 'h44 ? INT_MASK : a == 'h48 ? TRIG_MASK : SOFT_MASK));
    end
    wb(1'b1, OFS_SOFT_IN, 32'h0000_A5A5, 4'h2);
    rdw(OFS_SOFT_IN);
    check(rd, 32'h0000_A5BE);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({pin_out, logic_interrupt_zero, logic_interrupt_one, trig}, 32'h0);
    wr(OFS_OUT_WORD, 32'h0000_FFFF);
    wr(8'h54, 32'hFFFF_FFFF);
    for (int a = 0; a <= 'h54; a += 4) begin
      rdw(8'(a));
      check(rd, 32'h0);
    end
    stop_test();
  end
endmodule
